// *** common/rmsp_pkg.sv ***
// package: register map, field layout, constants and carriers for the reset mode selector
package rmsp_pkg;

  // ***********************************************
  // apb register byte offsets
  // ***********************************************
  localparam logic [7:0] OFF_MODE   = 8'h00;  // mode and pin status, read only
  localparam logic [7:0] OFF_OPTS   = 8'h04;  // build options, read only
  localparam logic [7:0] OFF_DDR0   = 8'h10;  // direction, port one .. four at 10..1c
  localparam logic [7:0] OFF_DATA0  = 8'h20;  // output latch, port one .. four at 20..2c
  localparam logic [7:0] OFF_PIN0   = 8'h30;  // pin level, port one .. four at 30..3c
  localparam logic [7:0] OFF_ALT    = 8'h40;  // alternate function enables
  localparam logic [7:0] OFF_STRIDE = 8'h04;

  // ***********************************************
  // field positions
  // ***********************************************
  localparam int MODE_SELF_BIT   = 0;
  localparam int WRALLOW_BIT     = 1;
  localparam int LVWI_ACTIVE_BIT = 2;
  localparam int ALT_SER_BIT     = 0;
  localparam int ALT_CMP_BIT     = 1;
  localparam int SER_CLK_BIT     = 7;  // port two bit 7
  localparam int SER_DI_BIT      = 6;  // port two bit 6
  localparam int SER_DO_BIT      = 5;  // port two bit 5
  localparam int CMP_BIT         = 6;  // port four bit 6
  localparam int SER_PORT        = 1;
  localparam int CMP_PORT        = 3;

  localparam int NUM_PORTS  = 4;
  localparam int PORT_WIDTH = 8;

  // ***********************************************
  // self-check rom window and reset defaults
  // ***********************************************
  localparam logic [12:0] SELF_ROM_START = 13'h1e80;
  localparam logic [12:0] SELF_ROM_END   = 13'h1fef;
  localparam logic [12:0] USER_RESET_PC  = 13'h0a80;
  localparam logic [7:0]  DDR_RESET      = 8'h00;
  localparam logic [7:0]  DATA_RESET     = 8'h00;
  localparam logic [31:0] POR_HOLD_CYCLES = 32'd4064;

  typedef enum logic {
    RMSP_SINGLE_CHIP,
    RMSP_SELF_CHECK
  } rmsp_mode_t;

  typedef struct packed {
    logic clkRc;        // 1 rc clock, 0 crystal
    logic irqLevel;     // 1 edge and level, 0 edge only
    logic serLsbFirst;  // 1 lsb first
    logic wdogEn;       // watchdog enabled
    logic lvwiEn;       // low voltage write inhibit enabled
  } rmsp_opts_t;

  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe;
  } rmsp_port_drv_t;

endpackage

// *** core/rmsp_sync.sv ***
// module: two-flop synchroniser for a vector of pin levels
module rmsp_sync #(
  parameter int          W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk,    // system clock
  input  wire logic         rst_n,  // async reset, active low
  input  wire logic [W-1:0] din,    // asynchronous pin levels
  output logic      [W-1:0] dout    // synchronised levels
);

  logic [W-1:0] stage1_ff;
  logic [W-1:0] stage2_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_ff <= RST;
      stage2_ff <= RST;
    end else begin
      stage1_ff <= din;
      stage2_ff <= stage1_ff;
    end
  end

  assign dout = stage2_ff;

endmodule

// *** core/rmsp_top.sv ***
// module: reset mode selection, port defaults, write-allow gating and bus clock divider
//
// Contract
// (R1) bus clock enable pulses every second clock, half the oscillator rate.
// (R2) eeprom program and erase allowed only while write-allow pin reads high.
// (R3) four 8-bit bidirectional ports, 32 individually programmable lines.
// (R4) every port line is an input after power-on and any reset.
// (R5) port two bits 5 to 7 carry serial clock, data-out and data-in.
// (R6) port four bit 6 carries the timer compare output.
// (R7) low reset input returns the block to its known start-up state.
// (R8) at reset release, normal interrupt level selects single-chip mode.
// (R9) at release, test voltage on interrupt plus high capture selects self-check.
// (R10) board holds reset low 4064 cycles after power-on, else minimum pulse.
// (R11) self-check mode starts the fixed program at rom 1e80 to 1fef.
// (R12) five fixed build options: clock, interrupt sense, bit order, watchdog, inhibit.
// (R13) mode is latched at release and held until the next reset.
module rmsp_top #(
  parameter rmsp_pkg::rmsp_opts_t BUILD_OPTS = '0  // fixed build options
) (
  input  wire logic        clk,             // 125 mhz oscillator clock
  input  wire logic        rst_n,           // async reset pin, active low
  input  wire logic        irqTestVoltage,  // comparator: interrupt pin at test_entry_voltage
  input  wire logic        captureInputPin, // capture_input_pin level
  input  wire logic        eepromWriteAllowPin, // write allow pin, pulled up
  input  wire logic        lowVoltageWriteInhibit, // supply below inhibit threshold
  input  wire logic        eeWriteReq,      // core requests eeprom program or erase
  output logic             eeWriteGo,       // program or erase permitted
  input  wire logic        serClkOut,       // serial port clock out
  input  wire logic        serDataOut,      // serial port data out
  output logic             serDataIn,       // serial port data in
  input  wire logic        compareOut,      // timer compare level
  input  wire logic [31:0] portPinIn,       // port pin levels, port one in low byte
  output logic      [31:0] portPinOut,      // port drive levels
  output logic      [31:0] portPinOe,       // port output enables, high drives
  output logic             busClkEn,        // one-cycle bus clock enable
  output logic             selfCheckMode,   // latched operating mode
  output logic      [12:0] startAddr,       // program start address after reset
  output logic      [12:0] selfRomEnd,      // last address of self-check program
  input  wire logic        psel,            // apb select
  input  wire logic        penable,         // apb enable
  input  wire logic        pwrite,          // apb write
  input  wire logic [7:0]  paddr,           // apb byte address
  input  wire logic [31:0] pwdata,          // apb write data
  output logic      [31:0] prdata,          // apb read data
  output logic             pready,          // apb ready
  output logic             pslverr          // apb error
);

  localparam int NP = rmsp_pkg::NUM_PORTS;
  localparam int PW = rmsp_pkg::PORT_WIDTH;

  // ***********************************************
  // pin synchronisers
  // ***********************************************
  logic [35:0] pinsSync;
  logic        irqTestS;
  logic        capS;
  logic        wrAllowS;
  logic        lvwiS;
  logic [31:0] portS;

  // write-allow resets high, matching its pull-up
  rmsp_sync #(.W(36), .RST(36'h2_0000_0000)) u_sync (
    .clk  (clk),
    .rst_n(rst_n),
    .din  ({irqTestVoltage, captureInputPin, eepromWriteAllowPin, lowVoltageWriteInhibit, portPinIn}),
    .dout (pinsSync)
  );

  assign irqTestS = pinsSync[35];
  assign capS     = pinsSync[34];
  assign wrAllowS = pinsSync[33];
  assign lvwiS    = pinsSync[32];
  assign portS    = pinsSync[31:0];

  // ***********************************************
  // bus clock divider
  // ***********************************************
  logic divPhase_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      divPhase_ff <= 1'b0;
    end else begin
      divPhase_ff <= ~divPhase_ff;  // (R1)
    end
  end

  assign busClkEn = divPhase_ff;  // (R1)

  // ***********************************************
  // mode latch at reset release
  // ***********************************************
  // pins reach the capture flop two clocks after release; settle_ff
  // counts those clocks so the synchroniser's reset value is never
  // taken for a pin level. later pin changes cannot flip the mode
  logic [1:0]  settle_ff;
  logic        captured_ff;
  logic        modeSelf_ff;
  logic        nxt_modeSelf;
  logic [12:0] startAddr_ff;
  logic        captureNow;

  assign nxt_modeSelf = irqTestS & capS;              // (R8) (R9)
  assign captureNow   = settle_ff[1] & ~captured_ff;  // (R13)

  // as deep as the synchroniser
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      settle_ff <= 2'h0;
    end else begin
      settle_ff <= {settle_ff[0], 1'b1};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      captured_ff  <= 1'b0;  // (R7)
      modeSelf_ff  <= 1'b0;
      startAddr_ff <= rmsp_pkg::USER_RESET_PC;
    end else if (captureNow) begin
      captured_ff  <= 1'b1;  // (R13)
      modeSelf_ff  <= nxt_modeSelf;
      startAddr_ff <= nxt_modeSelf ? rmsp_pkg::SELF_ROM_START : rmsp_pkg::USER_RESET_PC;  // (R11)
    end
  end

  assign selfCheckMode = modeSelf_ff;
  assign startAddr     = startAddr_ff;
  assign selfRomEnd    = rmsp_pkg::SELF_ROM_END;  // (R11)

  // ***********************************************
  // eeprom write gating
  // ***********************************************
  logic writeAllowed;

  assign writeAllowed = wrAllowS & ~(BUILD_OPTS.lvwiEn & lvwiS);  // (R2)
  assign eeWriteGo    = eeWriteReq & writeAllowed;               // (R2)

  // ***********************************************
  // port registers
  // ***********************************************
  logic [NP-1:0][PW-1:0] ddr_ff;
  logic [NP-1:0][PW-1:0] data_ff;
  logic [1:0]            altEn_ff;
  logic                  wrEn;
  logic                  rdEn;

  assign wrEn = psel & penable & pwrite;
  assign rdEn = psel & penable & ~pwrite;

  function automatic logic hitPort(input logic [7:0] a, input logic [7:0] base, input int idx);
    hitPort = (a == 8'(base + 8'(idx) * rmsp_pkg::OFF_STRIDE));
  endfunction

  rmsp_pkg::rmsp_port_drv_t drv [NP];
  logic [31:0]              drvOut;
  logic [31:0]              drvOe;

  genvar gp;
  generate
    for (gp = 0; gp < NP; gp++) begin : g_port
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          ddr_ff[gp]  <= rmsp_pkg::DDR_RESET;  // (R4)
          data_ff[gp] <= rmsp_pkg::DATA_RESET;
        end else if (wrEn && hitPort(paddr, rmsp_pkg::OFF_DDR0, gp)) begin
          ddr_ff[gp] <= pwdata[PW-1:0];  // (R3)
        end else if (wrEn && hitPort(paddr, rmsp_pkg::OFF_DATA0, gp)) begin
          data_ff[gp] <= pwdata[PW-1:0];
        end
      end
      always_comb begin
        drv[gp].dout = data_ff[gp];
        drv[gp].oe   = ddr_ff[gp];  // (R3)
      end
      assign drvOut[gp*PW +: PW] = drv[gp].dout;
      assign drvOe[gp*PW +: PW]  = drv[gp].oe;
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      altEn_ff <= 2'h0;
    end else if (wrEn && paddr == rmsp_pkg::OFF_ALT) begin
      altEn_ff <= pwdata[1:0];
    end
  end

  // ***********************************************
  // alternate function overlay
  // ***********************************************
  logic [31:0] overOe;
  logic [31:0] overVal;
  logic [31:0] overMask;
  localparam int SCK = rmsp_pkg::SER_PORT*PW + rmsp_pkg::SER_CLK_BIT;
  localparam int SDO = rmsp_pkg::SER_PORT*PW + rmsp_pkg::SER_DO_BIT;
  localparam int SDI = rmsp_pkg::SER_PORT*PW + rmsp_pkg::SER_DI_BIT;
  localparam int CMP = rmsp_pkg::CMP_PORT*PW + rmsp_pkg::CMP_BIT;

  always_comb begin
    overMask = '0;
    overVal  = '0;
    overOe   = '0;
    if (altEn_ff[rmsp_pkg::ALT_SER_BIT]) begin
      overMask[SCK] = 1'b1;  // (R5)
      overMask[SDO] = 1'b1;
      overMask[SDI] = 1'b1;
      overVal[SCK]  = serClkOut;
      overVal[SDO]  = serDataOut;
      overOe[SCK]   = 1'b1;
      overOe[SDO]   = 1'b1;
    end
    if (altEn_ff[rmsp_pkg::ALT_CMP_BIT]) begin
      overMask[CMP] = 1'b1;  // (R6)
      overVal[CMP]  = compareOut;
      overOe[CMP]   = 1'b1;
    end
  end

  logic [31:0] portOutFinal;
  logic [31:0] portOeFinal;
  assign serDataIn = portS[SDI] & altEn_ff[rmsp_pkg::ALT_SER_BIT];  // (R5)

  // shared pins override the port latch only while their function is on
  assign portOutFinal = (drvOut & ~overMask) | (overVal & overMask);  // (R5) (R6)
  assign portOeFinal  = (drvOe & ~overMask) | (overOe & overMask);    // (R5) (R6)
  assign portPinOut   = portOutFinal;
  assign portPinOe    = portOeFinal;

  // ***********************************************
  // apb read mux
  // ***********************************************
  // port index of a bank sits just above the word stride
  localparam int STRIDE_LSB = $clog2(rmsp_pkg::OFF_STRIDE);
  localparam int SEL_W      = $clog2(NP);

  logic [31:0]      rdMux;
  logic             addrHit;
  logic [SEL_W-1:0] portSel;
  logic             hitDdr;
  logic             hitData;
  logic             hitPin;

  function automatic logic hitBank(input logic [7:0] a, input logic [7:0] base);
    hitBank = 1'b0;
    for (int i = 0; i < NP; i++) begin
      hitBank = hitBank | hitPort(a, base, i);
    end
  endfunction

  assign portSel = paddr[STRIDE_LSB +: SEL_W];
  assign hitDdr  = hitBank(paddr, rmsp_pkg::OFF_DDR0);
  assign hitData = hitBank(paddr, rmsp_pkg::OFF_DATA0);
  assign hitPin  = hitBank(paddr, rmsp_pkg::OFF_PIN0);

  always_comb begin
    rdMux   = '0;
    addrHit = 1'b1;
    if (paddr == rmsp_pkg::OFF_MODE) begin
      rdMux[rmsp_pkg::MODE_SELF_BIT]   = modeSelf_ff;
      rdMux[rmsp_pkg::WRALLOW_BIT]     = writeAllowed;
      rdMux[rmsp_pkg::LVWI_ACTIVE_BIT] = lvwiS;
    end else if (paddr == rmsp_pkg::OFF_OPTS) begin
      rdMux[$bits(BUILD_OPTS)-1:0] = BUILD_OPTS;  // (R12)
    end else if (paddr == rmsp_pkg::OFF_ALT) begin
      rdMux[1:0] = altEn_ff;
    end else if (hitDdr) begin
      rdMux[PW-1:0] = ddr_ff[portSel];  // (R4)
    end else if (hitData) begin
      rdMux[PW-1:0] = data_ff[portSel];
    end else if (hitPin) begin
      rdMux[PW-1:0] = portS[portSel*PW +: PW];  // (R3)
    end else begin
      addrHit = 1'b0;
    end
  end

  assign prdata  = rdEn ? rdMux : 32'h0000_0000;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addrHit;

  // ***********************************************
  // assertions
  // ***********************************************
  a_div_half: assert property (@(posedge clk) disable iff (!rst_n)  // (R1)
    busClkEn |=> !busClkEn ##1 busClkEn) else $error("bus clock enable not every second cycle");
  a_ee_block: assert property (@(posedge clk) disable iff (!rst_n)  // (R2)
    eeWriteGo |-> wrAllowS) else $error("eeprom write with allow pin low");
  a_ee_allow: assert property (@(posedge clk) disable iff (!rst_n)  // (R2)
    (eeWriteReq && wrAllowS && !lvwiS) |-> eeWriteGo) else $error("eeprom write wrongly blocked");
  a_oe_reset: assert property (@(posedge clk)  // (R4)
    $rose(rst_n) |-> portPinOe == 32'h0000_0000) else $error("port not input after reset");
  a_mode_hold: assert property (@(posedge clk) disable iff (!rst_n)  // (R13)
    captured_ff |=> $stable(modeSelf_ff) && $stable(startAddr)) else $error("mode changed after capture");
  a_mode_self: assert property (@(posedge clk) disable iff (!rst_n)  // (R9)
    (captureNow && irqTestS && capS) |=> selfCheckMode && startAddr == rmsp_pkg::SELF_ROM_START)
    else $error("self-check not taken");
  a_mode_single: assert property (@(posedge clk) disable iff (!rst_n)  // (R8)
    (captureNow && !irqTestS) |=> !selfCheckMode && startAddr == rmsp_pkg::USER_RESET_PC)
    else $error("single-chip not taken");
  a_mode_nocap: assert property (@(posedge clk) disable iff (!rst_n)  // (R9)
    (captureNow && irqTestS && !capS) |=> !selfCheckMode) else $error("self-check taken with capture low");
  a_cmp_pin: assert property (@(posedge clk) disable iff (!rst_n)  // (R6)
    altEn_ff[rmsp_pkg::ALT_CMP_BIT] |-> portPinOe[CMP] && portPinOut[CMP] == compareOut)
    else $error("compare pin not driven");
  a_ser_pins: assert property (@(posedge clk) disable iff (!rst_n)  // (R5)
    altEn_ff[rmsp_pkg::ALT_SER_BIT] |-> portPinOe[SCK] && portPinOe[SDO] && !portPinOe[SDI])
    else $error("serial pins wrong direction");
  a_ser_data: assert property (@(posedge clk) disable iff (!rst_n)  // (R5)
    altEn_ff[rmsp_pkg::ALT_SER_BIT] |-> portPinOut[SCK] == serClkOut && portPinOut[SDO] == serDataOut)
    else $error("serial pins not driven");
  a_port_plain: assert property (@(posedge clk) disable iff (!rst_n)  // (R3)
    (altEn_ff == 2'h0) |-> portPinOe == drvOe && portPinOut == drvOut) else $error("port pins not from latches");

  c_self: cover property (@(posedge clk) disable iff (!rst_n) $rose(selfCheckMode));
  c_single: cover property (@(posedge clk) disable iff (!rst_n) captureNow && !nxt_modeSelf);
  c_ee_go: cover property (@(posedge clk) disable iff (!rst_n) eeWriteGo);
  c_ee_blk: cover property (@(posedge clk) disable iff (!rst_n) eeWriteReq && !eeWriteGo);
  c_alt: cover property (@(posedge clk) disable iff (!rst_n) altEn_ff == 2'h3);

endmodule

// *** sim/rmsp_board.sv ***
// board reset circuit and self-check fixture model driving the mode and write-allow pins
module rmsp_board (
  input  wire logic clk,                  // system clock
  output logic      rst_n,                // reset pin, active low
  output logic      irqTestVoltage,       // interrupt pin at test entry voltage
  output logic      captureInputPin,      // capture input level
  output logic      eepromWriteAllowPin   // write allow pin level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic allowDriven = 1'b0;
  logic allowLevel  = 1'b0;
  // ***********************************************
  // pins
  // ***********************************************
  // an undriven pin floats high through the weak pull-up
  assign eepromWriteAllowPin = allowDriven ? allowLevel : 1'b1;
  initial begin
    rst_n = 1'b0;
    irqTestVoltage = 1'b0;
    captureInputPin = 1'b0;
  end
  // pins are set up before release and held low for the full count
  task automatic hold_reset(input int cycles, input logic tst, input logic cap);
    @(posedge clk);
    rst_n <= 1'b0;
    irqTestVoltage <= tst;
    captureInputPin <= cap;
    repeat (cycles) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  task automatic set_pins(input logic tst, input logic cap, input logic drv, input logic lvl);
    @(posedge clk);
    irqTestVoltage <= tst;
    captureInputPin <= cap;
    allowDriven <= drv;
    allowLevel <= lvl;
  endtask
endmodule

// *** sim/testbench.sv ***
// self-checking bench for reset mode selection, port defaults and write-allow gating
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam rmsp_pkg::rmsp_opts_t OPTS = rmsp_pkg::rmsp_opts_t'(5'h15);
  logic clk = 1'b0;
  logic rst_n, irqTst, capPin, allowPin;
  logic lowVdd = 1'b0, eeReq = 1'b0, eeGo, serDi;
  logic serClk = 1'b0, serDo = 1'b0, cmpOut = 1'b0;
  logic [31:0] pinIn = 32'h0, pinOut, pinOe, prdata, pwdata = 32'h0, rd;
  logic busClkEn, selfMode, pready, pslverr, err;
  logic [12:0] startAddr, romEnd;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  int errors = 0, cmpCount = 0, pulses;
  logic prev;
  initial forever #4 clk = ~clk;
  rmsp_board u_board (.clk(clk), .rst_n(rst_n), .irqTestVoltage(irqTst), .captureInputPin(capPin),
    .eepromWriteAllowPin(allowPin));
  rmsp_top #(.BUILD_OPTS(OPTS)) u_dut (.clk(clk), .rst_n(rst_n), .irqTestVoltage(irqTst),
    .captureInputPin(capPin), .eepromWriteAllowPin(allowPin), .lowVoltageWriteInhibit(lowVdd),
    .eeWriteReq(eeReq), .eeWriteGo(eeGo), .serClkOut(serClk), .serDataOut(serDo), .serDataIn(serDi),
    .compareOut(cmpOut), .portPinIn(pinIn), .portPinOut(pinOut), .portPinOe(pinOe), .busClkEn(busClkEn),
    .selfCheckMode(selfMode), .startAddr(startAddr), .selfRomEnd(romEnd), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // ***********************************************
  // bench tasks
  // ***********************************************
  task automatic test_done;
    if (errors == 0 && cmpCount > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmpCount++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    if (n >= 50) chk(32'h1, 32'h0);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask
  // ***********************************************
  // tests
  // ***********************************************
  initial begin
    u_board.hold_reset(rmsp_pkg::POR_HOLD_CYCLES, 1'b0, 1'b0);
    wait_clk(6);
    chk(pinOe, 32'h0);
    chk(selfMode, 1'b0);
    chk(startAddr, rmsp_pkg::USER_RESET_PC);
    pulses = 0;
    prev = 1'b0;
    repeat (10) begin
      @(negedge clk);
      if (busClkEn === 1'b1) pulses += (prev === 1'b1) ? 100 : 1;
      prev = busClkEn;
    end
    chk(pulses, 5);
    apb(1'b0, rmsp_pkg::OFF_OPTS, 32'h0);
    chk(rd, {27'h0, OPTS});
    apb(1'b0, 8'h80, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, err}, 32'h1);
    pinIn <= 32'h1234_5678;
    for (int p = 0; p < 4; p++) begin
      apb(1'b1, rmsp_pkg::OFF_DDR0 + 8'(4 * p), 32'h5a ^ p);
      apb(1'b1, rmsp_pkg::OFF_DATA0 + 8'(4 * p), 32'ha5 + p);
      apb(1'b0, rmsp_pkg::OFF_DDR0 + 8'(4 * p), 32'h0);
      chk(rd, 32'h5a ^ p);
      chk({pinOe[8*p+:8], pinOut[8*p+:8]}, {8'(8'h5a ^ p), 8'(8'ha5 + p)});
      apb(1'b0, rmsp_pkg::OFF_PIN0 + 8'(4 * p), 32'h0);
      chk(rd, {24'h0, pinIn[8*p+:8]});
    end
    apb(1'b1, rmsp_pkg::OFF_ALT, 32'h3);
    apb(1'b0, rmsp_pkg::OFF_ALT, 32'h0);
    chk(rd, 32'h3);
    {serClk, serDo, cmpOut} <= 3'h5;
    wait_clk(1);
    chk({pinOe[15:8], pinOut[15:8]}, {8'hbb, 8'h86});
    chk({pinOe[31:24], pinOut[31:24]}, {8'h59, 8'he8});
    pinIn <= 32'h0000_4000;
    wait_clk(4);
    chk(serDi, 1'b1);
    pinIn <= 32'h0;
    wait_clk(4);
    chk(serDi, 1'b0);
    eeReq <= 1'b1;
    wait_clk(4);
    chk(eeGo, 1'b1);
    apb(1'b1, rmsp_pkg::OFF_MODE, 32'h1);
    apb(1'b0, rmsp_pkg::OFF_MODE, 32'h0);
    chk(rd, 32'h2);
    u_board.set_pins(1'b0, 1'b0, 1'b1, 1'b0);
    wait_clk(4);
    chk(eeGo, 1'b0);
    u_board.set_pins(1'b0, 1'b0, 1'b0, 1'b0);
    lowVdd <= 1'b1;
    wait_clk(4);
    chk(eeGo, 1'b0);
    lowVdd <= 1'b0;
    wait_clk(4);
    chk(eeGo, 1'b1);
    for (int m = 0; m < 4; m++) begin
      u_board.hold_reset(20, m[1], m[0]);
      wait_clk(6);
      chk(pinOe, 32'h0);
      chk(selfMode, m[1] & m[0]);
      chk(startAddr, (m == 3) ? rmsp_pkg::SELF_ROM_START : rmsp_pkg::USER_RESET_PC);
      chk(romEnd, rmsp_pkg::SELF_ROM_END);
      u_board.set_pins(~m[1], ~m[0], 1'b0, 1'b0);
      wait_clk(6);
      chk(selfMode, m[1] & m[0]);
      apb(1'b1, rmsp_pkg::OFF_DDR0, 32'hff);
    end
    test_done();
  end
  initial begin
    wait_clk(20000);
    errors++;
    test_done();
  end
endmodule
